/* File: hw/ovr_regs_params.svh */
// Register offsets, field positions, reset values and constants
`ifndef OVR_REGS_PARAMS_SVH
`define OVR_REGS_PARAMS_SVH
`define OFS_THRESHOLD 12'h211
`define OFS_CONFIG 12'h213
`define OFS_INIT_STATUS 12'h270
`define OFS_MODE_2 12'h29A
`define OFS_MODE_3 12'h29B
`define RST_THRESHOLD 8'hF2
`define RST_CONFIG 8'h07
`define RST_MODE_2 8'h0F
`define RST_MODE_3 8'h04
`define MODE_2_LOW 8'h06
`define MODE_3_LOW 8'h00
`define CFG_EN_BIT 3
`define CFG_N_MSB 2
`define CFG_WMASK 8'h0F
`define EXT_BASE 16'h0004
`define INIT_CYCLES 8'h20
`endif

/* File: hw/ovr_pkg.sv */
// Types shared by the over-range and mode register block
`default_nettype none
package ovr_pkg;
	typedef enum logic [1:0] {
		MODE_HIGH_PERF = 2'b00,
		MODE_LOW_POWER = 2'b01,
		MODE_RESERVED = 2'b10
	} power_mode_t;
	typedef logic [11:0] sample_t;
endpackage
`default_nettype wire

/* File: hw/range_flag_chan.sv */
// One channel's threshold compare with minimum pulse extension
`include "ovr_regs_params.svh"
`default_nettype none
module range_flag_chan
	import ovr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic sample_valid,
	input wire sample_t sample,
	input wire logic [7:0] threshold,
	input wire logic [2:0] ext_exp,
	input wire logic enable,
	output logic flag
);
	typedef struct packed {
		logic flag;
		logic [15:0] hold;
	} chan_state_t;

	chan_state_t st_r;
	chan_state_t st_nxt;
	logic [11:0] mag;
	logic hit;

	// Magnitude of two's complement sample; most negative saturates
	always_comb begin
		mag = sample[11] ? 12'(~sample + 12'h001) : sample;
		if (sample == 12'h800) begin
			mag = 12'h7FF;
		end
		// Threshold scales the 8-bit value onto the 11-bit magnitude, in steps of 8
		hit = ({1'b0, mag[10:0]} >= {1'b0, threshold, 3'h0});
	end

	// Extension counter reloads on each hit, flag drops when it expires
	always_comb begin
		st_nxt = st_r;
		if (sample_valid) begin
			if (hit) begin
				st_nxt.hold = 16'(`EXT_BASE << ext_exp) - 16'h0001;
				st_nxt.flag = 1'b1;
			end else if (st_r.hold != 16'h0000) begin
				st_nxt.hold = st_r.hold - 16'h0001;
			end else begin
				st_nxt.flag = 1'b0;
			end
		end
		if (!enable) begin
			st_nxt.flag = 1'b0;
			st_nxt.hold = 16'h0000;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign flag = st_r.flag;

	AST_FLAG_OFF_WHEN_DISABLED: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		!enable |=> !flag)
		else $error("flag high while outputs disabled");
	AST_HIT_RAISES_FLAG: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		sample_valid && hit && enable |=> flag)
		else $error("flag missed a threshold hit");
endmodule
`default_nettype wire

/* File: hw/ovr_regs.sv */
// Over-range detection, init status and power mode register bank
`include "ovr_regs_params.svh"
`default_nettype none
module ovr_regs
	import ovr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic sample_valid,
	input wire sample_t samp_a,
	input wire sample_t samp_b,
	input wire sample_t samp_c,
	input wire sample_t samp_d,
	output logic chan_a_range_flag,
	output logic chan_b_range_flag,
	output logic chan_c_range_flag,
	output logic chan_d_range_flag,
	output logic init_done,
	output logic [7:0] power_mode_code_2,
	output logic [7:0] power_mode_code_3,
	output logic low_power_active
);
	typedef struct packed {
		logic [7:0] threshold;
		logic [7:0] config_r;
		logic [7:0] mode2;
		logic [7:0] mode3;
		logic [7:0] init_cnt;
		logic done;
		logic [7:0] rdata;
		logic lp;
		logic [3:0] flag;
	} reg_state_t;

	reg_state_t st_r;
	reg_state_t st_nxt;
	logic [3:0] flag_w;
	sample_t samp_arr [4];

	// Decode a mode pair into one operating mode
	function automatic power_mode_t mode_of(input logic [7:0] m2,
		input logic [7:0] m3);
		if (m2 == `MODE_2_LOW && m3 == `MODE_3_LOW) begin
			return MODE_LOW_POWER;
		end else if (m2 == `RST_MODE_2 && m3 == `RST_MODE_3) begin
			return MODE_HIGH_PERF;
		end
		return MODE_RESERVED;
	endfunction

	assign samp_arr[0] = samp_a;
	assign samp_arr[1] = samp_b;
	assign samp_arr[2] = samp_c;
	assign samp_arr[3] = samp_d;

	// One detector per channel, each fed only its own samples
	for (genvar i = 0; i < 4; i++) begin : g_chan
		range_flag_chan u_chan (
			.clk_sys(clk_sys),
			.arst_n(arst_n),
			.sample_valid(sample_valid),
			.sample(samp_arr[i]),
			.threshold(st_r.threshold),
			.ext_exp(st_r.config_r[`CFG_N_MSB:0]),
			.enable(st_r.config_r[`CFG_EN_BIT]),
			.flag(flag_w[i])
		);
	end

	// Writes, init counter and read data; reserved bits stay zero so
	// a careless host cannot set them
	always_comb begin
		st_nxt = st_r;
		if (!st_r.done) begin
			st_nxt.init_cnt = st_r.init_cnt + 8'h01;
			st_nxt.done = (st_r.init_cnt == `INIT_CYCLES - 8'h01);
		end
		if (reg_wr) begin
			unique case (reg_addr)
				`OFS_THRESHOLD: st_nxt.threshold = reg_wdata;
				`OFS_CONFIG: st_nxt.config_r = reg_wdata & `CFG_WMASK;
				`OFS_MODE_2: st_nxt.mode2 = reg_wdata;
				`OFS_MODE_3: st_nxt.mode3 = reg_wdata;
				default: ;
			endcase
		end
		st_nxt.rdata = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				`OFS_THRESHOLD: st_nxt.rdata = st_r.threshold;
				`OFS_CONFIG: st_nxt.rdata = st_r.config_r;
				`OFS_INIT_STATUS: st_nxt.rdata = {7'h00, st_r.done};
				`OFS_MODE_2: st_nxt.rdata = st_r.mode2;
				`OFS_MODE_3: st_nxt.rdata = st_r.mode3;
				default: st_nxt.rdata = 8'h00;
			endcase
		end
		st_nxt.lp = (mode_of(st_nxt.mode2, st_nxt.mode3) == MODE_LOW_POWER);
		// Extra stage so the flag pins come straight from a flip-flop
		st_nxt.flag = flag_w;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '{threshold: `RST_THRESHOLD, config_r: `RST_CONFIG,
				mode2: `RST_MODE_2, mode3: `RST_MODE_3, init_cnt: 8'h00,
				done: 1'b0, rdata: 8'h00, lp: 1'b0, flag: 4'h0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata = st_r.rdata;
	assign init_done = st_r.done;
	assign power_mode_code_2 = st_r.mode2;
	assign power_mode_code_3 = st_r.mode3;
	assign low_power_active = st_r.lp;
	assign chan_a_range_flag = st_r.flag[0];
	assign chan_b_range_flag = st_r.flag[1];
	assign chan_c_range_flag = st_r.flag[2];
	assign chan_d_range_flag = st_r.flag[3];

	AST_FLAGS_LOW_DISABLED: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		!st_r.config_r[`CFG_EN_BIT] ##1 !st_r.config_r[`CFG_EN_BIT]
		|=> st_r.flag == 4'h0)
		else $error("range flag high while disabled");
	AST_INIT_STICKY: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		init_done |=> init_done)
		else $error("init done dropped");
	AST_INIT_READ: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		reg_rd && reg_addr == `OFS_INIT_STATUS
		|=> reg_rdata == {7'h00, $past(init_done)})
		else $error("init status read wrong");
	AST_CFG_RSVD_ZERO: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		st_r.config_r[7:4] == 4'h0)
		else $error("reserved config bits set");
	AST_MODE2_WRITE: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		reg_wr && reg_addr == `OFS_MODE_2
		|=> power_mode_code_2 == $past(reg_wdata))
		else $error("mode 2 write lost");
	AST_MODE3_WRITE: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		reg_wr && reg_addr == `OFS_MODE_3
		|=> power_mode_code_3 == $past(reg_wdata))
		else $error("mode 3 write lost");
	AST_THRESH_WRITE: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		reg_wr && reg_addr == `OFS_THRESHOLD
		|=> st_r.threshold == $past(reg_wdata))
		else $error("threshold write lost");
	AST_LP_DECODE: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		low_power_active |-> power_mode_code_2 == `MODE_2_LOW
		&& power_mode_code_3 == `MODE_3_LOW)
		else $error("low power flag without low power codes");
endmodule
`default_nettype wire

/* File: verification/ovr_host.sv */
// Host model driving the register strobes
`default_nettype none
module ovr_host (
	input wire logic clk_sys,
	output logic reg_wr,
	output logic reg_rd,
	output logic [11:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle bus at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 12'h000;
		reg_wdata = 8'h00;
	end
	// Callers pass reserved config bits as zero
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		reg_wdata = ~d; // Stale data must not matter
	endtask
	// Read data is registered at the taking edge and sampled half a cycle later
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk_sys);
		d = reg_rdata;
		reg_rd = 1'b0;
		reg_addr = ~a;
	endtask
endmodule
`default_nettype wire

/* File: verification/overrange_detect_and_mode_regs_bench.sv */
// Bench for the over-range and power mode register bank
`include "ovr_regs_params.svh"
`default_nettype none
module overrange_detect_and_mode_regs_bench import ovr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic arst_n, reg_wr, reg_rd, sample_valid, init_done, low_power_active;
	logic [11:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, power_mode_code_2, power_mode_code_3;
	logic [7:0] v;
	sample_t samp_a, samp_b, samp_c, samp_d;
	logic fa, fb, fc, fd;
	int fails = 0;
	int n_compared = 0;
	localparam logic [11:0] RA [5] = '{`OFS_INIT_STATUS, `OFS_THRESHOLD,
		`OFS_CONFIG, `OFS_MODE_2, `OFS_MODE_3};
	localparam logic [7:0] RV [5] = '{8'h01, `RST_THRESHOLD, `RST_CONFIG,
		`RST_MODE_2, `RST_MODE_3};
	always #5 clk_sys = ~clk_sys;
	ovr_host host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	ovr_regs DUT (.clk_sys(clk_sys), .arst_n(arst_n), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .sample_valid(sample_valid),
		.samp_a(samp_a), .samp_b(samp_b), .samp_c(samp_c), .samp_d(samp_d),
		.chan_a_range_flag(fa), .chan_b_range_flag(fb),
		.chan_c_range_flag(fc), .chan_d_range_flag(fd),
		.init_done(init_done), .power_mode_code_2(power_mode_code_2),
		.power_mode_code_3(power_mode_code_3),
		.low_power_active(low_power_active));
	// Compare one value and count it
	task automatic chk(input logic [7:0] seen, exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic flags(input logic [3:0] exp, input string what);
		chk({4'h0, fa, fb, fc, fd}, {4'h0, exp}, what);
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatched %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		arst_n = 1'b0;
		sample_valid = 1'b1;
		{samp_a, samp_b, samp_c, samp_d} = '0;
		repeat (5) @(posedge clk_sys);
		@(negedge clk_sys);
		arst_n = 1'b1;
		chk({7'h00, init_done}, 8'h00, "init_done");
		// Host stays off the bus until init completes
		for (int i = 0; i < 100 && init_done !== 1'b1; i++)
			@(negedge clk_sys);
		if (init_done !== 1'b1) begin
			fails++;
			wrap_up();
		end
		for (int i = 0; i < 5; i++) begin
			host.rd(RA[i], v);
			chk(v, RV[i], $sformatf("reg %h", RA[i]));
		end
		$display("test reset values done");
		host.wr(`OFS_CONFIG, 8'h08);
		host.rd(`OFS_CONFIG, v);
		chk(v, 8'h08, "config");
		host.wr(`OFS_INIT_STATUS, 8'hFF);
		host.rd(`OFS_INIT_STATUS, v);
		chk(v, 8'h01, "init_status write");
		host.rd(12'h000, v);
		chk(v, 8'h00, "unmapped");
		$display("test access kinds done");
		// Calibration and link enables sit outside and stay cleared;
		// the bench sample rate is far below the low power rate limit
		host.wr(`OFS_MODE_2, 8'h06);
		host.wr(`OFS_MODE_3, 8'h00);
		repeat (2) @(negedge clk_sys);
		chk(power_mode_code_2, `MODE_2_LOW, "code 2 low");
		chk(power_mode_code_3, `MODE_3_LOW, "code 3 low");
		chk({7'h00, low_power_active}, 8'h01, "lpa");
		host.wr(`OFS_MODE_2, 8'h0F);
		host.wr(`OFS_MODE_3, 8'h04);
		repeat (2) @(negedge clk_sys);
		chk({7'h00, low_power_active}, 8'h00, "lpa high");
		$display("test power modes done");
		// Level 1024: channels a and c hit, b and d sit one below
		host.wr(`OFS_THRESHOLD, 8'h80);
		@(negedge clk_sys);
		{samp_a, samp_b} = {12'h400, 12'hC01};
		{samp_c, samp_d} = {12'hC00, 12'h3FF};
		@(negedge clk_sys);
		{samp_a, samp_b, samp_c, samp_d} = '0;
		repeat (2) @(negedge clk_sys);
		flags(4'b1010, "flags hit");
		// N is 0 here: four cycles, the last one seen here
		repeat (2) @(negedge clk_sys);
		flags(4'b1010, "flags held");
		repeat (10) @(negedge clk_sys);
		flags(4'b0000, "flags expired");
		// N of 1 doubles the hold to eight cycles
		host.wr(`OFS_CONFIG, 8'h09);
		@(negedge clk_sys);
		samp_d = 12'h400;
		@(negedge clk_sys);
		samp_d = 12'h000;
		repeat (8) @(negedge clk_sys);
		flags(4'b0001, "flag held n1");
		repeat (2) @(negedge clk_sys);
		flags(4'b0000, "flag expired n1");
		samp_a = 12'h800;
		repeat (4) @(negedge clk_sys);
		flags(4'b1000, "flag saturated");
		host.wr(`OFS_CONFIG, 8'h00);
		repeat (2) @(negedge clk_sys);
		flags(4'b0000, "flags disabled");
		$display("test range flags done");
		wrap_up();
	end
endmodule
`default_nettype wire
